// ---- hdl/wesup_consts.svh ----
// Constants for the weighing error supervisor: offsets, codes, limits, reset values.
// Assumes inclusion by the top module, the checker and the bench.
`ifndef WESUP_CONSTS_SVH
`define WESUP_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define WESUP_OFF_INSTR_ERR   12'h000
`define WESUP_OFF_CMD_ERR     12'h004
`define WESUP_OFF_CTRL        12'h008
`define WESUP_OFF_STATUS      12'h00C
`define WESUP_OFF_WR_CHECK    12'h010
`define WESUP_OFF_RATE        12'h014
`define WESUP_OFF_OVL_HI      12'h018
`define WESUP_OFF_OVL_LO      12'h01C
`define WESUP_OFF_SCALE_BASE  12'h040

// ==========================================================
// Control register fields
`define WESUP_CTRL_NORMAL_BIT 0
`define WESUP_CTRL_OVLCHK_BIT 1
`define WESUP_CTRL_RESET      32'h0000_0000

// ==========================================================
// Error codes (decimal values as printed)
`define WESUP_CODE_NONE       10'd0
`define WESUP_CODE_NOT_NORMAL 10'd3
`define WESUP_CODE_OVERLOAD   10'd4
`define WESUP_CODE_OVERRANGE  10'd5
`define WESUP_CODE_UNDERLOAD  10'd6
`define WESUP_CODE_UNDERRANGE 10'd7
`define WESUP_CODE_EXC_SHORT  10'd10
`define WESUP_CODE_SENSE_ERR  10'd11
`define WESUP_CODE_SIG_ERR    10'd12
`define WESUP_CODE_INVALID    10'd14
`define WESUP_CODE_DIGITS     10'd20
`define WESUP_CODE_DIGITS_ALT 10'd191
`define WESUP_CODE_BAD_ADDR   10'd103
`define WESUP_CODE_BAD_COUNT  10'd104

// ==========================================================
// Write-request checks, digit limit and register reset values
`define WESUP_WR_ADDR_MIN     16'h9C41
`define WESUP_WR_ADDR_MAX     16'hC350
`define WESUP_WR_COUNT_MAX    8'h06
`define WESUP_DIGIT_LIMIT     32'd999999
`define WESUP_RATE_RESET      8'h00
`define WESUP_OVL_HI_RESET    32'h7FFF_FFFF
`define WESUP_OVL_LO_RESET    32'h8000_0000

`endif

// ---- hdl/wesup_pkg.sv ----
// Types for the weighing error supervisor.
// Assumes the constants header is available on the include path.
package wesup_pkg;
    typedef logic [9:0]  wesup_code_t;
    typedef logic [31:0] wesup_word_t;
endpackage : wesup_pkg

// ---- hdl/wesup_top.sv ----
// Error supervisor for a multi-scale weighing instrument.
// Assumes per-scale fault flags arrive asynchronously from transducer front ends,
// weights arrive on the mclk domain, and an APB master reaches the registers.
// Scale codes read back in bits [9:0] as plain decimal values; a scale's
// outputs go safe in the same cycle that its code register turns nonzero.
//
// What this block does
// R1: Zero code means no error present
// R2: Faulted scale forces its outputs safe
// R3: Any error drops process-active output
// R4: Instrument, command, eight scale code registers
// R5: Not normal state reports 003
// R6: Weight above upper limit reports 004
// R7: Weight below lower limit reports 006
// R8: Signal above converter range reports 005
// R9: Signal below converter range reports 007
// R10: Excitation short reports 010
// R11: Sense voltage out of range reports 011
// R12: Transducer signal out of range reports 012
// R13: Code 014 until enough samples after change
// R14: Weight needing seven digits reports 020
// R15: Scale codes follow their causes, no latching; command code holds until cleared or rechecked
// R16: Bad write address 103, count 104
// R17: Several conditions: one code by priority
`timescale 1ns/1ps
`include "wesup_consts.svh"

module wesup_top #(
    parameter int NUM_SCALES   = 8,
    parameter int SETTLE_SAMPS = 4,
    parameter int DOUT_W       = 8,
    parameter int AOUT_W       = 16
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [NUM_SCALES-1:0]         over_range_in,
    input  wire logic [NUM_SCALES-1:0]         under_range_in,
    input  wire logic [NUM_SCALES-1:0]         exc_short_in,
    input  wire logic [NUM_SCALES-1:0]         sense_err_in,
    input  wire logic [NUM_SCALES-1:0]         signal_err_in,
    input  wire logic [NUM_SCALES-1:0]         sample_valid,
    input  wire logic [NUM_SCALES*32-1:0]      weight_in,
    input  wire logic [NUM_SCALES*DOUT_W-1:0]  dout_req,
    input  wire logic [NUM_SCALES*AOUT_W-1:0]  aout_req,
    input  wire logic                          process_req,
    output logic      [NUM_SCALES*DOUT_W-1:0]  dout,
    output logic      [NUM_SCALES*AOUT_W-1:0]  aout,
    output logic                               process_active,
    output logic      [NUM_SCALES-1:0]         scale_fault
);
    import wesup_pkg::*;

    // ==========================================================
    // Reset release and pin synchronisers
    logic                  rst_s1_reg;
    logic                  rst_s2_reg;
    logic                  rstn;
    logic [5*NUM_SCALES-1:0] pin_s1_reg;
    logic [5*NUM_SCALES-1:0] pin_s2_reg;
    logic [5*NUM_SCALES-1:0] pins_raw;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rstn = rst_s2_reg;

    assign pins_raw = {exc_short_in, sense_err_in, signal_err_in, under_range_in,
                       over_range_in};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= pins_raw;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ==========================================================
    // Software registers
    wesup_word_t  ctrl_reg;
    logic [7:0]   rate_reg;
    logic signed [31:0] ovl_hi_reg;
    logic signed [31:0] ovl_lo_reg;
    wesup_code_t  cmd_err_reg;
    wesup_code_t  cmd_err_next;
    logic         rate_wr;
    logic         wr_en;
    logic         rd_en;
    logic         normal_state;
    logic         ovl_check;
    logic         ctrl_wr;
    logic         rate_sel_wr;
    logic         ovl_hi_wr;
    logic         ovl_lo_wr;
    logic         wr_check_wr;
    logic         cmd_clr_wr;

    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign normal_state = ctrl_reg[`WESUP_CTRL_NORMAL_BIT];
    assign ovl_check    = ctrl_reg[`WESUP_CTRL_OVLCHK_BIT];

    // Write strobes, one per register
    assign ctrl_wr     = wr_en && (paddr == `WESUP_OFF_CTRL);
    assign rate_sel_wr = wr_en && (paddr == `WESUP_OFF_RATE);
    assign ovl_hi_wr   = wr_en && (paddr == `WESUP_OFF_OVL_HI);
    assign ovl_lo_wr   = wr_en && (paddr == `WESUP_OFF_OVL_LO);
    assign wr_check_wr = wr_en && (paddr == `WESUP_OFF_WR_CHECK);
    assign cmd_clr_wr  = wr_en && (paddr == `WESUP_OFF_CMD_ERR);
    // Only a changed rate restarts the settle count
    assign rate_wr     = rate_sel_wr && (pwdata[7:0] != rate_reg);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            ctrl_reg <= `WESUP_CTRL_RESET;
        else if (ctrl_wr)
            ctrl_reg <= pwdata;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            rate_reg <= `WESUP_RATE_RESET;
        else if (rate_sel_wr)
            rate_reg <= pwdata[7:0];
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            ovl_hi_reg <= `WESUP_OVL_HI_RESET;
        else if (ovl_hi_wr)
            ovl_hi_reg <= pwdata;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            ovl_lo_reg <= `WESUP_OVL_LO_RESET;
        else if (ovl_lo_wr)
            ovl_lo_reg <= pwdata;
    end

    // Write-request check: start address in [31:16], count in [7:0]
    always_comb begin
        cmd_err_next = cmd_err_reg;
        if (wr_check_wr) begin
            if (pwdata[31:16] < `WESUP_WR_ADDR_MIN || pwdata[31:16] > `WESUP_WR_ADDR_MAX)
                cmd_err_next = `WESUP_CODE_BAD_ADDR;                        // R16
            else if (pwdata[7:0] == 8'h00 || pwdata[7:0] > `WESUP_WR_COUNT_MAX)
                cmd_err_next = `WESUP_CODE_BAD_COUNT;                       // R16
            else
                cmd_err_next = `WESUP_CODE_NONE;                            // R1
        end else if (cmd_clr_wr) begin
            cmd_err_next = `WESUP_CODE_NONE;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            cmd_err_reg <= `WESUP_CODE_NONE;
        else
            cmd_err_reg <= cmd_err_next;
    end

    // ==========================================================
    // Per-scale classification
    wesup_code_t scale_code_reg [NUM_SCALES];
    logic [NUM_SCALES-1:0] any_fault;
    logic [NUM_SCALES-1:0] fault_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_SCALES; g++) begin : g_scale
            logic [7:0]         settle_cnt_reg;
            logic signed [31:0] w;
            logic [31:0]        w_abs;
            wesup_code_t        code_next;
            logic               exc_s;
            logic               sense_s;
            logic               sig_s;
            logic               over_s;
            logic               under_s;
            logic               settled;
            logic               above_lim;
            logic               below_lim;
            logic               too_wide;

            assign w     = weight_in[g*32 +: 32];
            assign w_abs = w[31] ? 32'(-w) : w;

            // Synchronised fault levels of this scale
            assign exc_s   = pin_s2_reg[4*NUM_SCALES+g];
            assign sense_s = pin_s2_reg[3*NUM_SCALES+g];
            assign sig_s   = pin_s2_reg[2*NUM_SCALES+g];
            assign under_s = pin_s2_reg[NUM_SCALES+g];
            assign over_s  = pin_s2_reg[g];

            // Limits apply only while overload check is on
            assign above_lim = ovl_check && (w > ovl_hi_reg);
            assign below_lim = ovl_check && (w < ovl_lo_reg);
            assign too_wide  = (w_abs > `WESUP_DIGIT_LIMIT);
            assign settled   = (settle_cnt_reg >= 8'(SETTLE_SAMPS));

            // Sample count since power-up or rate change
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn)
                    settle_cnt_reg <= 8'h00;
                else if (rate_wr)
                    settle_cnt_reg <= 8'h00;                                // R13
                else if (sample_valid[g] && !settled)
                    settle_cnt_reg <= settle_cnt_reg + 8'h01;
            end

            // Fixed priority: hardware faults, range, state, settling, limits, digits
            always_comb begin
                if (exc_s)
                    code_next = `WESUP_CODE_EXC_SHORT;                      // R17 R10
                else if (sense_s)
                    code_next = `WESUP_CODE_SENSE_ERR;                      // R11
                else if (sig_s)
                    code_next = `WESUP_CODE_SIG_ERR;                        // R12
                else if (over_s)
                    code_next = `WESUP_CODE_OVERRANGE;                      // R8
                else if (under_s)
                    code_next = `WESUP_CODE_UNDERRANGE;                     // R9
                else if (!normal_state)
                    code_next = `WESUP_CODE_NOT_NORMAL;                     // R5
                else if (!settled)
                    code_next = `WESUP_CODE_INVALID;                        // R13
                else if (above_lim)
                    code_next = `WESUP_CODE_OVERLOAD;                       // R6
                else if (below_lim)
                    code_next = `WESUP_CODE_UNDERLOAD;                      // R7
                else if (too_wide)
                    code_next = `WESUP_CODE_DIGITS;                         // R14
                else
                    code_next = `WESUP_CODE_NONE;                           // R1
            end

            // Recomputed every cycle so codes clear with their cause
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn)
                    scale_code_reg[g] <= `WESUP_CODE_NONE;
                else
                    scale_code_reg[g] <= code_next;                         // R15
            end

            // Flag loads with the code so both agree in every cycle
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn)
                    fault_reg[g] <= 1'b0;
                else
                    fault_reg[g] <= (code_next != `WESUP_CODE_NONE);
            end
            assign any_fault[g] = fault_reg[g];

            // Safe outputs for faulted scale
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    dout[g*DOUT_W +: DOUT_W] <= '0;
                    aout[g*AOUT_W +: AOUT_W] <= '0;
                end else if (code_next != `WESUP_CODE_NONE) begin
                    dout[g*DOUT_W +: DOUT_W] <= '0;                         // R2
                    aout[g*AOUT_W +: AOUT_W] <= '0;                         // R2
                end else begin
                    dout[g*DOUT_W +: DOUT_W] <= dout_req[g*DOUT_W +: DOUT_W];
                    aout[g*AOUT_W +: AOUT_W] <= aout_req[g*AOUT_W +: AOUT_W];
                end
            end
        end
    endgenerate

    assign scale_fault = any_fault;

    // ==========================================================
    // Instrument error and process-active
    wesup_code_t instr_err_reg;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            instr_err_reg <= `WESUP_CODE_NONE;
        else
            instr_err_reg <= `WESUP_CODE_NONE;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            process_active <= 1'b0;
        end else begin
            process_active <= process_req && !(|any_fault)
                              && cmd_err_reg == `WESUP_CODE_NONE;           // R3
        end
    end

    // ==========================================================
    // APB read mux
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [11:0] scale_off;

    always_comb begin
        rd_word   = 32'h0000_0000;
        rd_hit    = 1'b1;
        scale_off = paddr - `WESUP_OFF_SCALE_BASE;
        unique case (paddr)
            `WESUP_OFF_INSTR_ERR: rd_word = {22'h0, instr_err_reg};         // R4
            `WESUP_OFF_CMD_ERR:   rd_word = {22'h0, cmd_err_reg};           // R4
            `WESUP_OFF_CTRL:      rd_word = ctrl_reg;
            `WESUP_OFF_STATUS:    rd_word = {23'h0, process_active,
                                             8'(any_fault)};
            `WESUP_OFF_WR_CHECK:  rd_word = 32'h0000_0000;
            `WESUP_OFF_RATE:      rd_word = {24'h0, rate_reg};
            `WESUP_OFF_OVL_HI:    rd_word = ovl_hi_reg;
            `WESUP_OFF_OVL_LO:    rd_word = ovl_lo_reg;
            default: begin
                if (paddr >= `WESUP_OFF_SCALE_BASE && scale_off[1:0] == 2'b00
                    && scale_off[11:2] < 10'(NUM_SCALES))
                    rd_word = {22'h0, scale_code_reg[scale_off[4:2]]};      // R4
                else
                    rd_hit = 1'b0;
            end
        endcase
    end

    assign pslverr = rd_en & ~rd_hit;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_word;
    end

endmodule : wesup_top

// ---- test/weighing_error_supervisor_tb.sv ----
// Self-checking bench for the weighing error supervisor.
// Assumes wesup_top with eight scales and the front end model.
`timescale 1ns/1ps
`include "wesup_consts.svh"
module weighing_error_supervisor_tb;
    import wesup_pkg::*;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, process_req = 0, run = 0;
    logic pready, pslverr, process_active, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv, rnd, tmp;
    logic [39:0] flt_req = 0, flt;
    logic [7:0] sv, scale_fault, fm;
    logic [255:0] weight_in = 0, wt;
    logic [63:0] dout_req = 0, dout;
    logic [127:0] aout_req = 0, aout;
    int error_cnt = 0, checks = 0, cyc = 0, ctrl = 0, hi, lo, cmd = 0, settle = 1, g, e;
    int wv[7] = '{1001, 1000, -1001, -1000, 1000000, -1000000, 999999};
    logic [31:0] cw[5] = '{32'h9C41_0006, 32'h9C40_0001, 32'hC351_0001, 32'hC350_0000,
        32'h9C41_0007};
    int ce[5] = '{0, 103, 103, 104, 104};
    int fc[5] = '{7, 5, 12, 11, 10};
    wesup_fe_model fe (.mclk(mclk), .run(run), .flt_req(flt_req), .flt(flt), .sample_valid(sv));
    wesup_top dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .over_range_in(flt[15:8]), .under_range_in(flt[7:0]),
        .exc_short_in(flt[39:32]), .sense_err_in(flt[31:24]), .signal_err_in(flt[23:16]),
        .sample_valid(sv), .weight_in(weight_in), .dout_req(dout_req), .aout_req(aout_req),
        .process_req(process_req), .dout(dout), .aout(aout),
        .process_active(process_active), .scale_fault(scale_fault));
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            finish_test();
        end
    end
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    function automatic int exp_code(int s);
        int w;
        w = $signed(weight_in[s*32+:32]);
        for (int k = 4; k >= 0; k--) if (flt_req[k*8+s]) return fc[k];
        if (!ctrl[0]) return 3;
        if (settle) return 14;
        if (ctrl[1] && w > hi) return 4;
        if (ctrl[1] && w < lo) return 6;
        return (w > 999999 || w < -999999) ? 20 : 0;
    endfunction : exp_code
    task automatic check_all();
        repeat (8) @(posedge mclk);
        for (int s = 0; s < 8; s++) begin
            e = exp_code(s);
            fm[s] = (e != 0);
            apb(1'h0, `WESUP_OFF_SCALE_BASE + 12'(4 * s), 32'h0);
            chk(rdv, e);
            chk(dout[s*8+:8], fm[s] ? 8'h00 : dout_req[s*8+:8]);
            chk(aout[s*16+:16], fm[s] ? 16'h0000 : aout_req[s*16+:16]);
        end
        apb(1'h0, `WESUP_OFF_STATUS, 32'h0);
        chk(rdv, {process_req && fm == 8'h00 && cmd == 0, fm});
        chk({24'h0, scale_fault}, {24'h0, fm});
        chk({31'h0, process_active}, {31'h0, process_req && fm == 8'h00 && cmd == 0});
    endtask : check_all
    task automatic finish_test();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    initial begin
        rnd = 32'h5624;
        dout_req <= {2{rnd}};
        rnd = lfsr(rnd);
        aout_req <= {4{rnd}};
        repeat (12) @(posedge mclk);
        rst_n <= 1'h1;
        run <= 1'h1;
        repeat (40) @(posedge mclk);
        settle = 0;
        apb(1'h0, `WESUP_OFF_CTRL, 32'h0);
        chk(rdv, `WESUP_CTRL_RESET);
        apb(1'h0, `WESUP_OFF_OVL_HI, 32'h0);
        chk(rdv, `WESUP_OVL_HI_RESET);
        apb(1'h0, `WESUP_OFF_OVL_LO, 32'h0);
        chk(rdv, `WESUP_OVL_LO_RESET);
        apb(1'h0, `WESUP_OFF_INSTR_ERR, 32'h0);
        chk(rdv, 32'h0);
        check_all();
        apb(1'h0, 12'h020, 32'h0);
        chk(rdv, 32'h0);
        chk({31'h0, err}, 32'h1);
        process_req <= 1'h1;
        apb(1'h1, `WESUP_OFF_CTRL, 32'h3);
        ctrl = 3;
        hi = 1000;
        lo = -1000;
        apb(1'h1, `WESUP_OFF_OVL_HI, hi);
        apb(1'h1, `WESUP_OFF_OVL_LO, lo);
        check_all();
        for (int i = 0; i < 7; i++) begin
            if (i == 4) begin
                apb(1'h1, `WESUP_OFF_CTRL, 32'h1);
                ctrl = 1;
            end
            rnd = lfsr(rnd);
            wt = '0;
            wt[rnd[2:0]*32+:32] = wv[i];
            weight_in <= wt;
            check_all();
        end
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            g = rnd[2:0];
            flt_req <= (i < 5) ? 40'h1 << (i * 8 + g) : (40'h1 << (32 + g)) | (40'h1 << (8 + g));
            check_all();
            flt_req <= '0;
            check_all();
        end
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, `WESUP_OFF_WR_CHECK, cw[i]);
            cmd = ce[i];
            apb(1'h0, `WESUP_OFF_CMD_ERR, 32'h0);
            chk(rdv, ce[i]);
        end
        check_all();
        apb(1'h1, `WESUP_OFF_CMD_ERR, 32'h0);
        cmd = 0;
        run <= 1'h0;
        apb(1'h1, `WESUP_OFF_RATE, 32'h5);
        settle = 1;
        check_all();
        run <= 1'h1;
        repeat (40) @(posedge mclk);
        settle = 0;
        check_all();
        finish_test();
    end
endmodule : weighing_error_supervisor_tb

// ---- test/wesup_asserts.sv ----
// Port checker for the weighing error supervisor.
// Assumes binding into wesup_top; sees only its ports.
`timescale 1ns/1ps
`include "wesup_consts.svh"
module wesup_asserts #(
    parameter int NUM_SCALES = 8,
    parameter int DOUT_W     = 8,
    parameter int AOUT_W     = 16
) (
    input wire logic                         mclk,
    input wire logic                         rst_n,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [11:0]                  paddr,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic [NUM_SCALES-1:0]        exc_short_in,
    input wire logic                         process_req,
    input wire logic [NUM_SCALES*DOUT_W-1:0] dout,
    input wire logic [NUM_SCALES*AOUT_W-1:0] aout,
    input wire logic                         process_active,
    input wire logic [NUM_SCALES-1:0]        scale_fault
);
    logic [1:0] live_reg;
    logic       rd;
    // Mirrors the design's two-flop reset release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) live_reg <= 2'h0;
        else live_reg <= {live_reg[0], 1'h1};
    end
    assign rd = psel && penable && !pwrite;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!live_reg[1]);
    for (genvar g = 0; g < NUM_SCALES; g++) begin : gs
        fault_safe_a: assert property (scale_fault[g] |-> dout[g*DOUT_W+:DOUT_W] == '0
            && aout[g*AOUT_W+:AOUT_W] == '0) else $error("faulted scale output live");
        exc_fault_a: assert property (exc_short_in[g] [*3] |=> scale_fault[g])
            else $error("excitation fault not flagged");
    end
    proc_off_a: assert property (|$past(scale_fault) |-> !process_active)
        else $error("process active with fault");
    proc_req_a: assert property (process_active |-> $past(process_req))
        else $error("process active unrequested");
    err_phase_a: assert property (pslverr |-> rd)
        else $error("error outside read access");
    no_wait_a: assert property (psel && penable |-> pready)
        else $error("wait state inserted");
    code_read_a: assert property (rd && paddr == `WESUP_OFF_SCALE_BASE |->
        (prdata[9:0] != 10'h0) == $past(scale_fault[0]) && prdata[31:10] == 22'h0)
        else $error("scale code read mismatch");
    stat_read_a: assert property (rd && paddr == `WESUP_OFF_STATUS |->
        prdata == {23'h0, $past(process_active), $past(scale_fault)})
        else $error("status read mismatch");
endmodule : wesup_asserts
bind wesup_top wesup_asserts #(.NUM_SCALES(NUM_SCALES), .DOUT_W(DOUT_W), .AOUT_W(AOUT_W)) chk (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exc_short_in(exc_short_in), .process_req(process_req), .dout(dout), .aout(aout),
    .process_active(process_active), .scale_fault(scale_fault));

// ---- test/wesup_fe_model.sv ----
// Transducer front end model: fault levels and sample pulses.
// Assumes the bench requests faults; samples pace at one in four cycles.
`timescale 1ns/1ps
module wesup_fe_model (
    input  wire logic        mclk,
    input  wire logic        run,
    input  wire logic [39:0] flt_req,
    output logic      [39:0] flt,
    output logic      [7:0]  sample_valid
);
    logic [1:0] div_reg = 2'h0;
    // Faults launched after the edge, as a converter would
    always_ff @(posedge mclk) begin
        div_reg <= div_reg + 2'h1;
        sample_valid <= (run && div_reg == 2'h0) ? 8'hFF : 8'h00;
        flt <= flt_req;
    end
endmodule : wesup_fe_model
